// File: hdl/expander_pkg.sv
// Constants and types for the 16-bit port expander register bank
// Function
// - Eight registers picked by a 3-bit index; 0-1 read only, 2-7 read/write.
// - Every register is reached the same way from the two-wire or the four-wire host.
// - Index 0 reads the port-a pins, bit n is pin n; writes do nothing.
// - Index 1 reads the port-b pins, bit n is pin n; writes are dropped.
// - Input readback has no reset value; it shows whatever the pins present.
// - Index 2 holds the port-a drive values and resets to all ones.
// - Index 3 holds the port-b drive values and resets to all ones.
// - Ones in index 4 invert matching bits of an index 0 read; resets to zeros.
// - Ones in index 5 invert matching bits of an index 1 read; resets to zeros.
// - Zero in index 6 drives the port-a pin from index 2; one floats it.
// - Zero in index 7 drives the port-b pin from index 3; one floats it.
// - In four-wire mode the device is selected only while all three select lines are low.
// - Two-wire mode works at any slow clock rate, with no timeout.
// - Bytes after the first alternate between port-a and port-b of one function.
// - Two-wire writes reach the register just after the stop condition.
package expander_pkg;
  localparam logic [2:0] IDX_PORT0_INPUT_STATE = 3'h0;
  localparam logic [2:0] IDX_PORT1_INPUT_STATE = 3'h1;
  localparam logic [2:0] IDX_PORT0_OUTPUT_VALUE = 3'h2;
  localparam logic [2:0] IDX_PORT1_OUTPUT_VALUE = 3'h3;
  localparam logic [2:0] IDX_PORT0_INVERT_MASK = 3'h4;
  localparam logic [2:0] IDX_PORT1_INVERT_MASK = 3'h5;
  localparam logic [2:0] IDX_PORT0_DIRECTION = 3'h6;
  localparam logic [2:0] IDX_PORT1_DIRECTION = 3'h7;
  // Index bits 2:1 pick the function, bit 0 the port
  localparam logic [1:0] FN_INPUT = 2'h0;
  localparam logic [1:0] FN_OUTPUT = 2'h1;
  localparam logic [1:0] FN_INVERT = 2'h2;
  localparam logic [1:0] FN_DIRECTION = 2'h3;
  localparam logic [2:0] PORT_TOGGLE = 3'h1;
  localparam logic [7:0] RST_OUTPUT_VALUE = 8'hff;
  localparam logic [7:0] RST_INVERT_MASK = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  // Four-wire command byte: index in 7:5, write flag, then a zero bit
  localparam int CMD_IDX_LSB = 5;
  localparam int CMD_WRITE_BIT = 4;
  localparam int CMD_ZERO_BIT = 3;
  // Two-wire command byte: five zero bits above the index
  localparam logic [4:0] I2C_CMD_PAD = 5'h00;
  // Upper three device address bits; value is arbitrary
  localparam logic [2:0] I2C_ADDR_HI = 3'h2;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_W = 24;
  typedef enum logic [5:0] {
    I2C_IDLE = 6'h01,
    I2C_ADDR = 6'h02,
    I2C_CMD = 6'h04,
    I2C_WDATA = 6'h08,
    I2C_RDATA = 6'h10,
    I2C_SKIP = 6'h20
  } i2c_state_e;
  typedef enum logic [3:0] {
    SPI_CMD = 4'h1,
    SPI_WDATA = 4'h2,
    SPI_RDATA = 4'h4,
    SPI_SKIP = 4'h8
  } spi_state_e;
endpackage

// File: hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 24
) (
  input wire logic ref_clk_i,
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] stable_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // No reset: pin data has no defined value until sampled
  always_ff @(posedge ref_clk_i) begin
    s1_q <= raw_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        stable_o[i] <= s3_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/io_expander_port_registers.sv
// Register bank, host serial slaves and pin drivers of the port expander
`timescale 1ns/1ns
`default_nettype none
module io_expander_port_registers (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic reset_pin_low_i,
  input wire logic mode_spi_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic addr_zero_i,
  input wire logic select_line_a_i,
  input wire logic select_line_b_i,
  input wire logic select_line_c_i,
  input wire logic [7:0] port_a_pin_i,
  output logic [7:0] port_a_pin_o,
  output logic [7:0] port_a_pin_oe_o,
  input wire logic [7:0] port_b_pin_i,
  output logic [7:0] port_b_pin_o,
  output logic [7:0] port_b_pin_oe_o
);
  logic [expander_pkg::SYNC_W-1:0] sync_s;
  logic [7:0] pin0_s, pin1_s;
  logic scl_s, sda_s, sel_a_s, sel_b_s, sel_c_s, addr0_s, spi_s, rstpin_s;
  logic rst_n, combined_select;
  logic scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [7:0] out_val_q [2];
  logic [7:0] inv_mask_q [2];
  logic [7:0] dir_q [2];

  pin_sync #(.W(expander_pkg::SYNC_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .raw_i({reset_pin_low_i, mode_spi_i, addr_zero_i, select_line_c_i, select_line_b_i,
            select_line_a_i, serial_data_i, serial_clk_i, port_b_pin_i, port_a_pin_i}),
    .stable_o(sync_s)
  );

  assign {rstpin_s, spi_s, addr0_s, sel_c_s, sel_b_s, sel_a_s, sda_s, scl_s, pin1_s,
          pin0_s} = sync_s;
  assign rst_n = nrst_i & rstpin_s;
  assign combined_select = sel_a_s | sel_b_s | sel_c_s;

  // Edge and bus-condition detection on the sampled serial lines
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n) begin
      // Track the live level so no false edge follows reset
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_ev = ~spi_s & scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev = ~spi_s & scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Shared read path, so both hosts see identical contents
  function automatic logic [7:0] rd_val(input logic [2:0] idx);
    logic [7:0] pins;
    pins = idx[0] ? pin1_s : pin0_s;
    unique case (idx[2:1])
      expander_pkg::FN_INPUT: rd_val = pins ^ inv_mask_q[idx[0]];
      expander_pkg::FN_OUTPUT: rd_val = out_val_q[idx[0]];
      expander_pkg::FN_INVERT: rd_val = inv_mask_q[idx[0]];
      expander_pkg::FN_DIRECTION: rd_val = dir_q[idx[0]];
    endcase
  endfunction

  // ---------------- Four-wire slave ----------------
  expander_pkg::spi_state_e spi_st_q;
  logic [2:0] spi_cnt_q, spi_idx_q;
  logic [7:0] spi_sh_q, spi_tx_q, spi_byte;
  logic sclk_rise, sclk_fall, spi_done, spi_wr;

  assign sclk_rise = spi_s & ~combined_select & scl_rise;
  assign sclk_fall = spi_s & ~combined_select & scl_fall;
  assign spi_byte = {spi_sh_q[6:0], sda_s};
  assign spi_done = sclk_rise && (spi_cnt_q == expander_pkg::LAST_BIT);
  assign spi_wr = spi_done && (spi_st_q == expander_pkg::SPI_WDATA);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n || !spi_s || combined_select) begin
      spi_st_q <= expander_pkg::SPI_CMD;
      spi_cnt_q <= 3'h0;
      spi_sh_q <= 8'h00;
      spi_tx_q <= 8'h00;
      spi_idx_q <= 3'h0;
    end else if (sclk_rise) begin
      spi_cnt_q <= spi_cnt_q + 3'h1;
      spi_sh_q <= spi_byte;
      if (spi_done) begin
        unique case (spi_st_q)
          expander_pkg::SPI_CMD: begin
            // A set zero bit marks a corrupt command; skip until deselect
            if (spi_byte[expander_pkg::CMD_ZERO_BIT]) begin
              spi_st_q <= expander_pkg::SPI_SKIP;
            end else begin
              spi_idx_q <= spi_byte[7:expander_pkg::CMD_IDX_LSB];
              if (spi_byte[expander_pkg::CMD_WRITE_BIT]) begin
                spi_st_q <= expander_pkg::SPI_WDATA;
              end else begin
                spi_st_q <= expander_pkg::SPI_RDATA;
                spi_tx_q <= rd_val(spi_byte[7:expander_pkg::CMD_IDX_LSB]);
              end
            end
          end
          expander_pkg::SPI_WDATA: begin
            spi_idx_q <= spi_idx_q ^ expander_pkg::PORT_TOGGLE;
          end
          expander_pkg::SPI_RDATA: begin
            spi_idx_q <= spi_idx_q ^ expander_pkg::PORT_TOGGLE;
            spi_tx_q <= rd_val(spi_idx_q ^ expander_pkg::PORT_TOGGLE);
          end
          expander_pkg::SPI_SKIP: begin
            spi_st_q <= expander_pkg::SPI_SKIP;
          end
        endcase
      end
    end else if (sclk_fall && spi_st_q == expander_pkg::SPI_RDATA) begin
      spi_tx_q <= {spi_tx_q[6:0], 1'b0};
    end
  end

  // Data leaves on falling edges; released as soon as the select drops
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= spi_s & ~combined_select & (spi_st_q == expander_pkg::SPI_RDATA);
      if (sclk_fall && spi_st_q == expander_pkg::SPI_RDATA) begin
        miso_o <= spi_tx_q[7];
      end
    end
  end

  // ---------------- Two-wire slave ----------------
  expander_pkg::i2c_state_e i2c_st_q;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_sh_q, i2c_tx_q;
  logic [2:0] i2c_idx_q;
  logic [6:0] dev_addr;
  logic i2c_rise, i2c_fall;
  logic pend_v_q [2];
  logic [2:0] pend_i_q [2];
  logic [7:0] pend_d_q [2];

  assign dev_addr = {expander_pkg::I2C_ADDR_HI, sel_c_s, sel_b_s, sel_a_s, addr0_s};
  assign i2c_rise = ~spi_s & scl_rise;
  assign i2c_fall = ~spi_s & scl_fall;

  // Purely edge driven: a stalled clock simply holds the state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n) begin
      i2c_idx_q <= 3'h0;
    end else if (i2c_rise && i2c_cnt_q == expander_pkg::ACK_SLOT) begin
      if (i2c_st_q == expander_pkg::I2C_CMD && serial_data_oe_o) begin
        i2c_idx_q <= i2c_sh_q[2:0];
      end else if (i2c_st_q == expander_pkg::I2C_WDATA ||
                   (i2c_st_q == expander_pkg::I2C_RDATA && !sda_s)) begin
        i2c_idx_q <= i2c_idx_q ^ expander_pkg::PORT_TOGGLE;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n || spi_s || stop_ev) begin
      i2c_st_q <= expander_pkg::I2C_IDLE;
      i2c_cnt_q <= 4'h0;
      i2c_sh_q <= 8'h00;
      i2c_tx_q <= 8'h00;
    end else if (start_ev) begin
      i2c_st_q <= expander_pkg::I2C_ADDR;
      i2c_cnt_q <= 4'h0;
    end else if (i2c_rise) begin
      if (i2c_cnt_q != expander_pkg::ACK_SLOT) begin
        i2c_sh_q <= {i2c_sh_q[6:0], sda_s};
        i2c_cnt_q <= i2c_cnt_q + 4'h1;
      end else begin
        i2c_cnt_q <= 4'h0;
        unique case (i2c_st_q)
          expander_pkg::I2C_IDLE, expander_pkg::I2C_SKIP, expander_pkg::I2C_WDATA: begin
            i2c_st_q <= i2c_st_q;
          end
          expander_pkg::I2C_ADDR: begin
            if (!serial_data_oe_o) begin
              i2c_st_q <= expander_pkg::I2C_SKIP;
            end else if (i2c_sh_q[0]) begin
              i2c_st_q <= expander_pkg::I2C_RDATA;
              i2c_tx_q <= rd_val(i2c_idx_q);
            end else begin
              i2c_st_q <= expander_pkg::I2C_CMD;
            end
          end
          expander_pkg::I2C_CMD: begin
            i2c_st_q <= serial_data_oe_o ? expander_pkg::I2C_WDATA : expander_pkg::I2C_SKIP;
          end
          expander_pkg::I2C_RDATA: begin
            // A missing host acknowledge ends the read until the next start
            if (sda_s) begin
              i2c_st_q <= expander_pkg::I2C_SKIP;
            end else begin
              i2c_tx_q <= rd_val(i2c_idx_q ^ expander_pkg::PORT_TOGGLE);
            end
          end
        endcase
      end
    end else if (i2c_fall && i2c_st_q == expander_pkg::I2C_RDATA &&
                 i2c_cnt_q != expander_pkg::ACK_SLOT) begin
      i2c_tx_q <= {i2c_tx_q[6:0], 1'b0};
    end
  end

  // Open-drain data: only ever pulls low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n || spi_s || start_ev || stop_ev) begin
      serial_data_oe_o <= 1'b0;
    end else if (i2c_fall) begin
      if (i2c_cnt_q == expander_pkg::ACK_SLOT) begin
        serial_data_oe_o <= (i2c_st_q == expander_pkg::I2C_ADDR && i2c_sh_q[7:1] == dev_addr) ||
                            (i2c_st_q == expander_pkg::I2C_CMD &&
                             i2c_sh_q[7:3] == expander_pkg::I2C_CMD_PAD) ||
                            (i2c_st_q == expander_pkg::I2C_WDATA);
      end else begin
        serial_data_oe_o <= (i2c_st_q == expander_pkg::I2C_RDATA) && !i2c_tx_q[7];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n) begin
      serial_data_o <= 1'b0;
    end else begin
      serial_data_o <= 1'b0;
    end
  end

  // Written bytes wait here, one slot per port, until the stop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n || spi_s || stop_ev) begin
      for (int p = 0; p < 2; p++) begin
        pend_v_q[p] <= 1'b0;
        pend_i_q[p] <= 3'h0;
        pend_d_q[p] <= 8'h00;
      end
    end else if (i2c_rise && i2c_cnt_q == expander_pkg::ACK_SLOT &&
                 i2c_st_q == expander_pkg::I2C_WDATA) begin
      pend_v_q[i2c_idx_q[0]] <= 1'b1;
      pend_i_q[i2c_idx_q[0]] <= i2c_idx_q;
      pend_d_q[i2c_idx_q[0]] <= i2c_sh_q;
    end
  end

  // ---------------- Register bank ----------------
  logic wr_v [3];
  logic [2:0] wr_i [3];
  logic [7:0] wr_d [3];

  always_comb begin
    wr_v[0] = spi_wr;
    wr_i[0] = spi_idx_q;
    wr_d[0] = spi_byte;
    for (int p = 0; p < 2; p++) begin
      wr_v[p + 1] = stop_ev & pend_v_q[p];
      wr_i[p + 1] = pend_i_q[p];
      wr_d[p + 1] = pend_d_q[p];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n) begin
      for (int p = 0; p < 2; p++) begin
        out_val_q[p] <= expander_pkg::RST_OUTPUT_VALUE;
        inv_mask_q[p] <= expander_pkg::RST_INVERT_MASK;
        dir_q[p] <= expander_pkg::RST_DIRECTION;
      end
    end else begin
      for (int s = 0; s < 3; s++) begin
        if (wr_v[s]) begin
          // Input indices fall through: writes there are dropped
          case (wr_i[s][2:1])
            expander_pkg::FN_OUTPUT: out_val_q[wr_i[s][0]] <= wr_d[s];
            expander_pkg::FN_INVERT: inv_mask_q[wr_i[s][0]] <= wr_d[s];
            expander_pkg::FN_DIRECTION: dir_q[wr_i[s][0]] <= wr_d[s];
            default: ;
          endcase
        end
      end
    end
  end

  // Pin drivers: a direction zero enables the driver
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n) begin
      port_a_pin_o <= expander_pkg::RST_OUTPUT_VALUE;
      port_b_pin_o <= expander_pkg::RST_OUTPUT_VALUE;
      port_a_pin_oe_o <= ~expander_pkg::RST_DIRECTION;
      port_b_pin_oe_o <= ~expander_pkg::RST_DIRECTION;
    end else begin
      port_a_pin_o <= out_val_q[0];
      port_b_pin_o <= out_val_q[1];
      port_a_pin_oe_o <= ~dir_q[0];
      port_b_pin_oe_o <= ~dir_q[1];
    end
  end

  // ---------------- Checks ----------------
  out_defaults_a: assert property (@(posedge ref_clk_i) !rst_n |=>
    out_val_q[0] == 8'hff && out_val_q[1] == 8'hff)
    else $error("output values not all ones after reset");
  mask_defaults_a: assert property (@(posedge ref_clk_i) !rst_n |=>
    inv_mask_q[0] == 8'h00 && inv_mask_q[1] == 8'h00 && dir_q[0] == 8'hff && dir_q[1] == 8'hff)
    else $error("mask or direction wrong after reset");
  drive_port_a_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    port_a_pin_oe_o == ~$past(dir_q[0]) && port_a_pin_o == $past(out_val_q[0]))
    else $error("port a driver does not follow its registers");
  drive_port_b_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    port_b_pin_oe_o == ~$past(dir_q[1]) && port_b_pin_o == $past(out_val_q[1]))
    else $error("port b driver does not follow its registers");
  select_miso_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    combined_select |=> !miso_oe_o)
    else $error("miso driven while not selected");
  ro_index_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    spi_wr && spi_idx_q[2:1] == expander_pkg::FN_INPUT |=>
    $stable(out_val_q[0]) && $stable(inv_mask_q[0]) && $stable(dir_q[0]))
    else $error("write to an input index changed a register");
  stop_commit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    stop_ev && pend_v_q[0] && pend_i_q[0][2:1] == expander_pkg::FN_OUTPUT |=>
    out_val_q[0] == $past(pend_d_q[0]))
    else $error("pending write not applied at stop");
  spi_alternate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    spi_wr |=> spi_idx_q == ($past(spi_idx_q) ^ 3'h1))
    else $error("burst index did not alternate ports");
  invert_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    spi_done && spi_st_q == expander_pkg::SPI_CMD && spi_byte[7:3] == 5'h00 |=>
    spi_tx_q == ($past(pin0_s) ^ $past(inv_mask_q[0])))
    else $error("port a readback not inverted by mask");
  i2c_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !spi_s && !scl_rise && !scl_fall && !start_ev && !stop_ev |=>
    i2c_st_q == $past(i2c_st_q))
    else $error("two-wire state moved without a clock edge");
endmodule
`default_nettype wire

// File: verification/serial_host.sv
// Host controller model that drives the expander's serial pins
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic sdo_o,
  output logic [2:0] sel_n_o
);
  int half = 4;
  initial begin
    sclk_o = 1'b0;
    sdo_o = 1'b1;
    sel_n_o = 3'h7;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Device is addressed only while all three lines are low
  task automatic spi_sel(input logic [2:0] lvl);
    sel_n_o = lvl;
    tick(half);
  endtask
  task automatic spi_end();
    tick(half);
    sel_n_o = 3'h7;
    // Released line must not keep showing its last bit
    sdo_o = ~sdo_o;
    tick(2 * half);
  endtask
  // Mode 0: drive before the rise, sample just before the fall
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdo_o = tx[i];
      tick(half);
      sclk_o = 1'b1;
      tick(half);
      rx[i] = miso_i;
      sclk_o = 1'b0;
    end
  endtask
  task automatic i2c_start();
    tick(1);
    sdo_o = 1'b1;
    tick(half - 1);
    sclk_o = 1'b1;
    tick(half);
    sdo_o = 1'b0;
    tick(half);
    sclk_o = 1'b0;
  endtask
  task automatic i2c_stop();
    tick(1);
    sdo_o = 1'b0;
    tick(half - 1);
    sclk_o = 1'b1;
    tick(half);
    sdo_o = 1'b1;
    tick(2 * half);
  endtask
  // Data only moves while the clock is low, so no false start or stop
  // Long low phase: the device lets go of its ack about five clocks late
  task automatic i2c_bit(input logic b, output logic r);
    tick(1);
    sdo_o = b;
    tick(half + half / 2 - 1);
    sclk_o = 1'b1;
    tick(half / 4);
    r = sda_i;
    tick(half / 2 - half / 4);
    sclk_o = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                          output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// File: verification/io_expander_port_registers_tb.sv
// Self-checking bench for the port expander register bank
`timescale 1ns/1ns
`default_nettype none
module io_expander_port_registers_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reset_pin_low_i = 1'b1;
  logic mode_spi_i = 1'b1;
  logic addr_zero_i = 1'b0;
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_b = 8'h00;
  logic [7:0] shadow [8];
  logic [7:0] wd [3];
  logic [7:0] rd [3];
  logic [7:0] rx;
  logic ack;
  logic [6:0] dev;
  logic [2:0] idx;
  logic bad_cmd = 1'b0;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  wire logic sclk, sdo, sda_o, sda_oe, miso, miso_oe;
  wire logic [2:0] sel_n;
  wire logic [7:0] pa_o, pa_oe, pb_o, pb_oe;
  // Open-drain data line with pull-up, tristate read line with pull-down
  wire logic sda_w = sdo & ~(sda_oe & ~sda_o);
  wire logic miso_w = miso_oe ? miso : 1'b0;
  wire logic [7:0] pin_a = (pa_oe & pa_o) | (~pa_oe & ext_a);
  wire logic [7:0] pin_b = (pb_oe & pb_o) | (~pb_oe & ext_b);
  always #5 ref_clk_i = ~ref_clk_i;
  serial_host i_host (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .miso_i(miso_w), .sclk_o(sclk),
    .sdo_o(sdo), .sel_n_o(sel_n));
  io_expander_port_registers i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .reset_pin_low_i(reset_pin_low_i), .mode_spi_i(mode_spi_i), .serial_clk_i(sclk),
    .serial_data_i(mode_spi_i ? sdo : sda_w), .serial_data_o(sda_o),
    .serial_data_oe_o(sda_oe), .miso_o(miso), .miso_oe_o(miso_oe),
    .addr_zero_i(addr_zero_i), .select_line_a_i(sel_n[0]), .select_line_b_i(sel_n[1]),
    .select_line_c_i(sel_n[2]), .port_a_pin_i(pin_a), .port_a_pin_o(pa_o),
    .port_a_pin_oe_o(pa_oe), .port_b_pin_i(pin_b), .port_b_pin_o(pb_o),
    .port_b_pin_oe_o(pb_oe));
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, about three times the ten thousand or so cycles the tests need
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      results();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] pin_lvl(input logic [7:0] o, input logic [7:0] d,
                                         input logic [7:0] e);
    return (~d & o) | (d & e);
  endfunction
  // Readback of input indices is pin level xor the invert mask
  function automatic logic [7:0] expv(input logic [2:0] i);
    if (i == 3'h0) return pin_lvl(shadow[2], shadow[6], ext_a) ^ shadow[4];
    if (i == 3'h1) return pin_lvl(shadow[3], shadow[7], ext_b) ^ shadow[5];
    return shadow[i];
  endfunction
  task automatic rst_shadow();
    shadow[2] = 8'hff;
    shadow[3] = 8'hff;
    shadow[4] = 8'h00;
    shadow[5] = 8'h00;
    shadow[6] = 8'hff;
    shadow[7] = 8'hff;
  endtask
  task automatic chk_pins();
    i_host.tick(4);
    check(pa_o, shadow[2]);
    check(pa_oe, ~shadow[6]);
    check(pb_o, shadow[3]);
    check(pb_oe, ~shadow[7]);
  endtask
  task automatic spi_acc(input logic [2:0] i, input logic wr, input int n,
                         input logic [2:0] sel);
    logic [7:0] cmd_rx;
    i_host.spi_sel(sel);
    i_host.spi_byte({i, wr, bad_cmd, 3'h0}, cmd_rx);
    for (int k = 0; k < n; k++) begin
      i_host.spi_byte(wd[k], rd[k]);
      if (wr && !bad_cmd && sel == 3'h0 && (i ^ k[0]) > 3'h1) shadow[i ^ k[0]] = wd[k];
    end
    i_host.spi_end();
  endtask
  task automatic spi_rd(input logic [2:0] i, input int n);
    spi_acc(i, 1'b0, n, 3'h0);
    for (int k = 0; k < n; k++) begin
      check(rd[k], expv(i ^ k[0]));
    end
  endtask
  task automatic i2c_w(input logic [7:0] tx);
    i_host.i2c_byte(tx, 1'b1, rx, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  initial begin
    void'($urandom(32'h9f80));
    ext_a = 8'($urandom);
    ext_b = 8'($urandom);
    rst_shadow();
    repeat (6) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    chk_pins();
    for (int i = 0; i < 8; i += 2) spi_rd(i[2:0], 3);
    $display("reset values done");
    // Random bursts, including dropped writes to the input indices
    for (int r = 0; r < 6; r++) begin
      idx = 3'(($urandom % 4) * 2);
      for (int k = 0; k < 3; k++) wd[k] = 8'($urandom);
      spi_acc(idx, 1'b1, 3, 3'h0);
      chk_pins();
      ext_a = 8'($urandom);
      ext_b = 8'($urandom);
      i_host.tick(8);
      spi_rd(3'h0, 3);
      spi_rd(idx, 2);
    end
    $display("random bursts done");
    // One select high at a time, then a corrupt command: the write must not land
    for (int j = 0; j < 4; j++) begin
      wd[0] = 8'($urandom);
      wd[1] = ~wd[0];
      bad_cmd = (j == 3);
      spi_acc(3'h2, 1'b1, 2, (j < 3) ? 3'(1 << j) : 3'h0);
      bad_cmd = 1'b0;
      spi_rd(3'h2, 2);
    end
    $display("select lines done");
    mode_spi_i = 1'b0;
    addr_zero_i = 1'($urandom);
    i_host.sel_n_o = 3'($urandom);
    dev = {expander_pkg::I2C_ADDR_HI, i_host.sel_n_o, addr_zero_i};
    i_host.tick(8);
    wd[0] = 8'($urandom);
    wd[1] = 8'($urandom);
    i_host.i2c_start();
    i2c_w({dev, 1'b0});
    i2c_w(8'h03);
    i2c_w(wd[0]);
    i2c_w(wd[1]);
    i_host.tick(8);
    check(pb_o, shadow[3]);
    i_host.i2c_stop();
    shadow[3] = wd[0];
    shadow[2] = wd[1];
    chk_pins();
    // Slow clock with no timeout
    i_host.half = 20;
    i_host.i2c_start();
    i2c_w({dev, 1'b0});
    i2c_w(8'h03);
    i_host.i2c_start();
    i2c_w({dev, 1'b1});
    i_host.i2c_byte(8'hff, 1'b0, rx, ack);
    check(rx, shadow[3]);
    i_host.i2c_byte(8'hff, 1'b1, rx, ack);
    check(rx, shadow[2]);
    i_host.i2c_stop();
    i_host.half = 4;
    $display("two-wire done");
    reset_pin_low_i = 1'b0;
    i_host.tick(8);
    reset_pin_low_i = 1'b1;
    i_host.tick(8);
    rst_shadow();
    chk_pins();
    $display("reset pin done");
    results();
  end
endmodule
`default_nettype wire
